// *** include/sas_pkg.sv ***
// Purpose: Constants for the 8-bit successive approximation sequencer
// Assumes: core_clk at 20 MHz, converter clock arrives on a pin
// Notes: Pins are levels; the converter clock is sampled, never used as a clock
`default_nettype none

package sas_pkg;
  localparam int SAS_WIDTH = 8;
  localparam logic [7:0] SAS_TRIAL_START = 8'h80;
  localparam logic [7:0] SAS_RESULT_RST = 8'h00;
  localparam logic [2:0] SAS_TOP_BIT = 3'h7;
  localparam logic [2:0] SAS_LOW_BIT = 3'h0;
  localparam int SAS_CONV_PERIODS = 9;
  localparam int SAS_SYNC_STAGES = 3;
  localparam int SAS_PINS = 4;
  localparam int SAS_PIN_CLK = 0;
  localparam int SAS_PIN_START = 1;
  localparam int SAS_PIN_READ = 2;
  localparam int SAS_PIN_COMP = 3;
  localparam logic [3:0] SAS_PIN_IDLE = 4'h3;
  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_HOLD,
    SAS_CONVERT,
    SAS_FINISH
  } sas_state_e;
endpackage : sas_pkg

`default_nettype wire

// *** logic/sas_sequencer.sv ***
// Purpose: Successive approximation control, start/busy handshake and tri-state result
// Assumes: All pins are asynchronous to core_clk and pass a three-stage synchroniser
// Notes: Converter clock must be well below core_clk so each level is seen
`default_nettype none

module sas_sequencer
  import sas_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic conv_clk,
  input wire logic start_n,
  input wire logic read_en,
  input wire logic comp_high,
  output logic busy_n,
  output logic [sas_pkg::SAS_WIDTH-1:0] data_out,
  output logic data_oe
);
  import sas_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [SAS_PINS-1:0] pin_raw;
  logic [SAS_PINS-1:0] pin_lvl;
  logic [SAS_PINS-1:0] pin_prev;

  assign pin_raw = {comp_high, read_en, start_n, conv_clk};

  genvar g;
  generate
    for (g = 0; g < SAS_PINS; g++) begin : g_sync
      logic [SAS_SYNC_STAGES-1:0] stage;
      always_ff @(posedge core_clk) begin
        if (srst) begin
          stage <= {SAS_SYNC_STAGES{SAS_PIN_IDLE[g]}};
        end else begin
          stage <= {stage[SAS_SYNC_STAGES-2:0], pin_raw[g]};
        end
      end
      // Level accepted once stages two and three agree
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pin_lvl[g] <= SAS_PIN_IDLE[g];
        end else if (stage[1] == stage[2]) begin
          pin_lvl[g] <= stage[2];
        end
      end
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pin_prev[g] <= SAS_PIN_IDLE[g];
        end else begin
          pin_prev[g] <= pin_lvl[g];
        end
      end
    end
  endgenerate

  logic clk_fall;
  logic start_low;
  assign clk_fall = pin_prev[SAS_PIN_CLK] & ~pin_lvl[SAS_PIN_CLK];
  assign start_low = ~pin_lvl[SAS_PIN_START];

  // ==========================================================
  // Sequencer
  sas_state_e state;
  logic [2:0] trial_bit;
  logic [SAS_WIDTH-1:0] sar;

  // States in which a converter clock fall decides a bit
  function automatic logic sas_in_trial(input sas_state_e s);
    return (s == SAS_HOLD) || (s == SAS_CONVERT);
  endfunction : sas_in_trial

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= SAS_IDLE;
    end else if (start_low) begin
      state <= SAS_HOLD;
    end else begin
      unique case (state)
        SAS_IDLE: begin
          state <= SAS_IDLE;
        end
        SAS_HOLD: begin
          if (clk_fall) begin
            state <= (trial_bit == SAS_LOW_BIT) ? SAS_FINISH : SAS_CONVERT;
          end
        end
        SAS_CONVERT: begin
          if (clk_fall && trial_bit == SAS_LOW_BIT) begin
            state <= SAS_FINISH;
          end
        end
        SAS_FINISH: begin
          if (clk_fall) begin
            state <= SAS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trial_bit <= SAS_TOP_BIT;
    end else if (start_low) begin
      trial_bit <= SAS_TOP_BIT;
    end else if (clk_fall && sas_in_trial(state) && trial_bit != SAS_LOW_BIT) begin
      trial_bit <= trial_bit - 3'h1;
    end
  end

  // Comparator high means the input sits above the trial level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sar <= SAS_RESULT_RST;
    end else if (start_low) begin
      sar <= SAS_TRIAL_START;
    end else if (clk_fall && sas_in_trial(state)) begin
      sar[trial_bit] <= pin_lvl[SAS_PIN_COMP];
      if (trial_bit != SAS_LOW_BIT) begin
        sar[trial_bit - 3'h1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_n <= 1'b1;
    end else if (start_low) begin
      busy_n <= 1'b0;
    end else if (state == SAS_FINISH && clk_fall) begin
      busy_n <= 1'b1;
    end
  end

  // ==========================================================
  // Tri-state result, reading leaves the register untouched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_out <= SAS_RESULT_RST;
    end else begin
      data_out <= sar;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= pin_lvl[SAS_PIN_READ];
    end
  end

endmodule : sas_sequencer

`default_nettype wire

// *** bench/sas_assertions.sv ***
// Purpose: Port checks of sas_sequencer
// Assumes: Pins held many cycles
// Notes: Bound in tb_top
`default_nettype none
module sas_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start_n,
  input wire logic read_en,
  input wire logic busy_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_oe_on: assert property ($rose(read_en) ##1 read_en[*6] |-> data_oe)
    else $error("oe late");
  a_oe_off: assert property ($fell(read_en) ##1 !read_en[*6] |-> !data_oe)
    else $error("oe stuck");
  a_start_busy: assert property (!start_n[*7] |-> !busy_n)
    else $error("busy late");
  a_start_load: assert property (!start_n[*8] |-> data_out == 8'h80)
    else $error("not held");
  a_busy_load: assert property ($fell(busy_n) |=> data_out == 8'h80)
    else $error("no load");
  a_busy_min: assert property ($fell(busy_n) |=> !busy_n[*8])
    else $error("busy short");
  a_done_start: assert property ($rose(busy_n) |-> $past(start_n, 6))
    else $error("early done");
  a_idle_hold: assert property (busy_n[*8] |-> $stable(data_out))
    else $error("result moved");
endmodule : sas_assertions
`default_nettype wire

// *** bench/sas_host_model.sv ***
// Purpose: Host clock and comparator
// Assumes: Falling core_clk drive
// Notes: Equal counts as above trial
`default_nettype none
module sas_host_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] vin,
  input wire logic [7:0] data_out,
  output logic conv_clk,
  output logic comp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div = 4'h0;
  initial conv_clk = 1'b1;
  always @(negedge core_clk) begin
    div <= div + 4'h1;
    if (srst || div == 4'hF) conv_clk <= srst | ~conv_clk;
  end
  assign comp_high = vin >= data_out;
endmodule : sas_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: Bench of sas_sequencer
// Assumes: 50 ns core_clk
// Notes: Falling edge drive
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic start_n = 1'b1;
  logic read_en = 1'b0;
  logic [7:0] vin = 8'h00;
  logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h66, 8'h81};
  logic conv_clk, comp_high, busy_n, data_oe;
  logic [7:0] data_out;
  int fails = 0;
  int checks = 0;
  always #25 core_clk = ~core_clk;
  sas_host_model host (.core_clk, .srst, .vin, .data_out, .conv_clk, .comp_high);
  sas_sequencer dut (.core_clk, .srst, .conv_clk, .start_n, .read_en, .comp_high, .busy_n,
    .data_out, .data_oe);
  task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic convert_and_read(input logic [7:0] v);
    int f;
    int n;
    logic p;
    vin = v;
    start_n = 1'b0;
    repeat (10) @(negedge core_clk);
    for (n = 0; n < 99 && !(p === 1'b0 && conv_clk === 1'b1); n++) begin
      p = conv_clk;
      @(negedge core_clk);
    end
    if (n == 99) begin
      fails++;
      tally_and_finish();
    end
    start_n = 1'b1;
    f = 0;
    for (n = 0; n < 400 && busy_n !== 1'b1; n++) begin
      p = conv_clk;
      @(negedge core_clk);
      f += int'(p === 1'b1 && conv_clk === 1'b0);
    end
    if (n == 400) begin
      fails++;
      tally_and_finish();
    end
    check("falls", 8'h09, f[7:0]);
    read_en = 1'b1;
    repeat (8) @(negedge core_clk);
    check("oe", 8'h01, {7'h00, data_oe});
    check("result", v, data_out);
    read_en = 1'b0;
    repeat (8) @(negedge core_clk);
    check("float", 8'h00, {7'h00, data_oe});
    check("kept", v, data_out);
  endtask : convert_and_read
  task automatic restart_mid_conversion(input logic [7:0] v);
    start_n = 1'b0;
    repeat (10) @(negedge core_clk);
    start_n = 1'b1;
    repeat (100) @(negedge core_clk);
    check("busy mid", 8'h00, {7'h00, busy_n});
    convert_and_read(v);
  endtask : restart_mid_conversion
  initial begin
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    foreach (vals[i]) convert_and_read(vals[i]);
    restart_mid_conversion(8'h5A);
    tally_and_finish();
  end
endmodule : tb_top
bind sas_sequencer sas_assertions chk (.core_clk, .srst, .start_n, .read_en, .busy_n,
  .data_out, .data_oe);
`default_nettype wire
